// ==== design/cpbc_boot_ctrl.sv ====
// cpbc_boot_ctrl: apb register file for codec processor run control,
// version readback and a few firmware commands.
// assumes an apb master on pclk; sequence info on the same clock.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
// Summary of operation
// - run register at 0x000 halts or runs
// - processor initializes before accepting commands
// - version word: product high, version low
// - version fields major, minor, patch
// - version read only after initialization
// - display delay: host value else default
// - deringing off returns success once the processor is ready
// - enabled report with null buffer rejected
// - signal init completion after run set
module cpbc_boot_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] default_display_delay,
    output logic processor_run,
    output logic dering_en,
    output logic [7:0] display_delay,
    output logic [3:0] report_en,
    output logic busy,
    output logic init_done_irq
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic run;             // run control bit
        logic dering;          // deringing enabled
        logic [7:0] dly_host;  // host display delay value
        logic dly_set;         // host delay command issued
        logic [7:0] dly_out;   // delay in use
        logic [31:0] addr;     // report buffer address
        logic [31:0] size;     // report buffer size
        logic [3:0] rep_en;    // report enables
        logic [7:0] result;    // last return code
        logic done_st;         // sticky init complete
        logic irq;             // init complete signal
        logic busy;            // busy indication
        logic [31:0] rdata;    // read data
        logic rdy;             // apb ready
        logic err;             // apb error
    } cpbc_reg_t;

    cpbc_reg_t q;
    cpbc_reg_t d;
    cpbc_seq_if sq ();

    logic setup;      // apb setup phase
    logic wr_acc;     // write takes effect
    logic mapped;     // address decodes
    logic [7:0] code; // command code
    logic en_flag;    // report enable flag

    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite && q.rdy && !q.err;
    assign code = pwdata[7:0];
    assign en_flag = pwdata[cpbc_pkg::CMD_EN_BIT];
    assign sq.run = q.run;

    // address decode of the eight words
    always_comb begin
        case (paddr)
            cpbc_pkg::OFF_RUN, cpbc_pkg::OFF_STATUS, cpbc_pkg::OFF_VERSION,
            cpbc_pkg::OFF_DELAY, cpbc_pkg::OFF_CMD, cpbc_pkg::OFF_ADDR,
            cpbc_pkg::OFF_SIZE, cpbc_pkg::OFF_RESULT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        // one wait-free answer: ready in the access cycle
        d.rdy = setup;
        d.err = setup && !mapped;
        if (setup && !pwrite) begin
            case (paddr)
                cpbc_pkg::OFF_RUN: d.rdata = {31'h0, q.run};
                cpbc_pkg::OFF_STATUS: d.rdata = {29'h0, q.done_st, sq.ready, q.busy};
                cpbc_pkg::OFF_VERSION: begin
                    // version only once init is complete
                    d.rdata = sq.ready ? cpbc_pkg::VERSION_WORD : 32'h0;
                end
                cpbc_pkg::OFF_DELAY: d.rdata = {24'h0, q.dly_host};
                cpbc_pkg::OFF_ADDR: d.rdata = q.addr;
                cpbc_pkg::OFF_SIZE: d.rdata = q.size;
                cpbc_pkg::OFF_RESULT: d.rdata = {24'h0, q.result};
                default: d.rdata = 32'h0;
            endcase
        end
        // register writes
        if (wr_acc) begin
            case (paddr)
                cpbc_pkg::OFF_RUN: d.run = pwdata[0];
                cpbc_pkg::OFF_DELAY: d.dly_host = pwdata[7:0];
                cpbc_pkg::OFF_ADDR: d.addr = pwdata;
                cpbc_pkg::OFF_SIZE: d.size = pwdata;
                cpbc_pkg::OFF_CMD: begin
                    if (!sq.ready) begin
                        // commands before internal init are refused with not ready
                        d.result = cpbc_pkg::RC_NOT_READY;
                    end else begin
                        case (code)
                            cpbc_pkg::CMD_DERING_OFF: begin
                                d.dering = 1'b0;
                                d.result = cpbc_pkg::RC_SUCCESS;
                            end
                            cpbc_pkg::CMD_DERING_ON: begin
                                d.dering = 1'b1;
                                d.result = cpbc_pkg::RC_SUCCESS;
                            end
                            cpbc_pkg::CMD_DISPLAY_DELAY: begin
                                d.dly_set = 1'b1;
                                d.result = cpbc_pkg::RC_SUCCESS;
                            end
                            cpbc_pkg::CMD_REPORT_BUF, cpbc_pkg::CMD_REPORT_MB,
                            cpbc_pkg::CMD_REPORT_MV, cpbc_pkg::CMD_USER_REPORT: begin
                                // enable with null buffer, or with empty user buffer, is rejected
                                if (en_flag && (q.addr == 32'h0 ||
                                    (code == cpbc_pkg::CMD_USER_REPORT && q.size == 32'h0))) begin
                                    d.result = cpbc_pkg::RC_BAD_PARAM;
                                end else begin
                                    d.rep_en[code[1:0]] = en_flag;
                                    d.result = cpbc_pkg::RC_SUCCESS;
                                end
                            end
                            default: d.result = cpbc_pkg::RC_BAD_CMD;
                        endcase
                    end
                end
                default: begin
                    // status bit done is write one to clear
                    if (paddr == cpbc_pkg::OFF_STATUS && pwdata[cpbc_pkg::ST_DONE_BIT]) begin
                        d.done_st = 1'b0;
                    end
                end
            endcase
        end
        // completion sets the sticky bit; set beats a same-cycle clear
        if (sq.done) begin
            d.done_st = 1'b1;
        end
        d.irq = sq.done;
        // halting forgets the host delay setting
        if (!d.run) begin
            d.dly_set = 1'b0;
        end
        d.dly_out = d.dly_set ? d.dly_host : default_display_delay;
        d.busy = d.run && !sq.ready;
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{run: cpbc_pkg::RUN_RST, dering: cpbc_pkg::DERING_RST,
                   dly_host: cpbc_pkg::DELAY_RST, dly_set: 1'b0,
                   dly_out: cpbc_pkg::DELAY_RST, addr: 32'h0, size: 32'h0,
                   rep_en: 4'h0, result: cpbc_pkg::RESULT_RST, done_st: 1'b0,
                   irq: 1'b0, busy: 1'b0, rdata: 32'h0, rdy: 1'b0, err: 1'b0};
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // sequencer and outputs
    // ----------------------------------------------------------------
    cpbc_init_seq u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .sq(sq)
    );

    assign prdata = q.rdata;
    assign pready = q.rdy;
    assign pslverr = q.err;
    assign processor_run = q.run;
    assign dering_en = q.dering;
    assign display_delay = q.dly_out;
    assign report_en = q.rep_en;
    assign busy = q.busy;
    assign init_done_irq = q.irq;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    run_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == cpbc_pkg::OFF_RUN |=> processor_run == $past(pwdata[0]))
        else $error("run register did not take written value");
    busy_start_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(processor_run) |-> busy ##1 busy[*8])
        else $error("busy not held after run set");
    busy_end_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        processor_run && busy |-> ##[1:260] !busy)
        else $error("busy never released");
    version_gate_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup && !pwrite && paddr == cpbc_pkg::OFF_VERSION
        |=> prdata == ($past(sq.ready) ? cpbc_pkg::VERSION_WORD : 32'h0))
        else $error("version read not gated by init");
    dering_off_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == cpbc_pkg::OFF_CMD && sq.ready && code == cpbc_pkg::CMD_DERING_OFF
        |=> !dering_en && q.result == cpbc_pkg::RC_SUCCESS)
        else $error("deringing off failed");
    null_report_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == cpbc_pkg::OFF_CMD && sq.ready && en_flag
        && code == cpbc_pkg::CMD_USER_REPORT && q.size == 32'h0
        |=> q.result == cpbc_pkg::RC_BAD_PARAM && report_en == $past(report_en))
        else $error("empty user report accepted");
    // first cycle after reset still shows the reset value of the delay
    delay_default_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $past(presetn) && !q.dly_set |-> display_delay == $past(default_display_delay))
        else $error("default display delay not used");
    init_signal_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        sq.done |=> init_done_irq && q.done_st)
        else $error("init completion not signalled");
endmodule : cpbc_boot_ctrl

// ==== design/cpbc_init_seq.sv ====
// cpbc_init_seq: models the processor's own start-up after enable.
// assumes run comes from a register on the same clock.
`timescale 1ns/1ps
module cpbc_init_seq (
    input wire logic pclk,
    input wire logic presetn,
    cpbc_seq_if.seq sq
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        cpbc_pkg::cpbc_seq_state_t st; // sequencer state
        logic [11:0] cnt;              // init cycle counter
        logic ready;                   // ready for commands
        logic done;                    // completion pulse
    } cpbc_seq_reg_t;

    cpbc_seq_reg_t q;
    cpbc_seq_reg_t d;

    assign sq.ready = q.ready;
    assign sq.done = q.done;

    // next state: halt, run internal init, then ready
    always_comb begin
        d = q;
        d.done = 1'b0;
        case (q.st)
            cpbc_pkg::SEQ_HALT: begin
                d.ready = 1'b0;
                if (sq.run) begin
                    d.st = cpbc_pkg::SEQ_INIT;
                    d.cnt = 12'h000;
                end
            end
            cpbc_pkg::SEQ_INIT: begin
                if (!sq.run) begin // halted mid-init
                    d.st = cpbc_pkg::SEQ_HALT;
                end else if (q.cnt == cpbc_pkg::INIT_LAST) begin
                    d.st = cpbc_pkg::SEQ_READY;
                    d.ready = 1'b1;
                    d.done = 1'b1;
                end else begin
                    d.cnt = q.cnt + 12'h001;
                end
            end
            cpbc_pkg::SEQ_READY: begin
                if (!sq.run) begin // halt drops readiness
                    d.st = cpbc_pkg::SEQ_HALT;
                    d.ready = 1'b0;
                end
            end
            default: begin
                d.st = cpbc_pkg::SEQ_HALT;
                d.ready = 1'b0;
            end
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{st: cpbc_pkg::SEQ_HALT, cnt: 12'h000, ready: 1'b0, done: 1'b0};
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    init_length_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(q.ready) |-> $past(q.cnt) == cpbc_pkg::INIT_LAST && $past(sq.run))
        else $error("ready rose before init count finished");
    done_ready_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        q.done |-> q.ready && !$past(q.ready))
        else $error("done pulse without fresh readiness");
    halt_clears_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !sq.run |=> !q.ready)
        else $error("ready held while halted");
endmodule : cpbc_init_seq

// ==== include/cpbc_pkg.sv ====
// cpbc_pkg: offsets, fields, reset values, codes and timing of the
// codec processor boot control block.
// assumes a 125 MHz apb clock and 32-bit word-aligned registers.
package cpbc_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] OFF_RUN = 12'h000;     // run control
    localparam logic [11:0] OFF_STATUS = 12'h004;  // busy / ready / init done
    localparam logic [11:0] OFF_VERSION = 12'h008; // microcode version word
    localparam logic [11:0] OFF_DELAY = 12'h00c;   // host display delay
    localparam logic [11:0] OFF_CMD = 12'h010;     // command launch
    localparam logic [11:0] OFF_ADDR = 12'h014;    // report buffer address
    localparam logic [11:0] OFF_SIZE = 12'h018;    // report buffer size
    localparam logic [11:0] OFF_RESULT = 12'h01c;  // last return code
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int ST_BUSY_BIT = 0;   // processor enabled, not ready
    localparam int ST_READY_BIT = 1;  // init finished, accepts commands
    localparam int ST_DONE_BIT = 2;   // sticky init complete, w1c
    localparam int CMD_EN_BIT = 8;    // report enable flag in command word
    localparam int VER_MAJOR_LSB = 12;
    localparam int VER_MINOR_LSB = 8;
    localparam int VER_PATCH_LSB = 0;
    localparam int VER_PRODUCT_LSB = 16;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic RUN_RST = 1'b0;      // processor halted
    localparam logic DERING_RST = 1'b1;   // deringing on
    localparam logic [7:0] DELAY_RST = 8'h00;
    localparam logic [7:0] RESULT_RST = 8'h00;
    // ----------------------------------------------------------------
    // version word (values arbitrary)
    // ----------------------------------------------------------------
    localparam logic [15:0] PRODUCT_NUMBER = 16'h5a5a; // arbitrary value
    localparam logic [3:0] VER_MAJOR = 4'h1;
    localparam logic [3:0] VER_MINOR = 4'h0;
    localparam logic [7:0] VER_PATCH = 8'h00;
    localparam logic [31:0] VERSION_WORD = {PRODUCT_NUMBER, VER_MAJOR, VER_MINOR, VER_PATCH};
    // ----------------------------------------------------------------
    // command codes and return codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_DERING_OFF = 8'h01;
    localparam logic [7:0] CMD_DERING_ON = 8'h02;
    localparam logic [7:0] CMD_DISPLAY_DELAY = 8'h03; // display_delay_command
    localparam logic [7:0] CMD_REPORT_BUF = 8'h04;    // report index 0
    localparam logic [7:0] CMD_REPORT_MB = 8'h05;     // report index 1
    localparam logic [7:0] CMD_REPORT_MV = 8'h06;     // report index 2
    localparam logic [7:0] CMD_USER_REPORT = 8'h07;   // user_report_setup
    localparam logic [7:0] RC_SUCCESS = 8'h00;        // success_return_code
    localparam logic [7:0] RC_BAD_PARAM = 8'h01;      // bad_parameter_code
    localparam logic [7:0] RC_BAD_CMD = 8'h02;
    localparam logic [7:0] RC_NOT_READY = 8'h03;
    // ----------------------------------------------------------------
    // internal initialization timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int INIT_TIME_NS = 2000;
    localparam int INIT_CYCLES = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam logic [11:0] INIT_LAST = 12'(INIT_CYCLES - 1);
    // init sequencer states
    typedef enum logic [2:0] {
        SEQ_HALT = 3'b001,
        SEQ_INIT = 3'b010,
        SEQ_READY = 3'b100
    } cpbc_seq_state_t;
endpackage : cpbc_pkg

// ==== include/cpbc_seq_if.sv ====
// cpbc_seq_if: run request and readiness between register side and
// the initialization sequencer; both ends on the same clock.
`timescale 1ns/1ps
interface cpbc_seq_if;
    logic run;   // processor enabled
    logic ready; // internal init finished
    logic done;  // one-cycle init complete pulse
    modport ctl (output run, input ready, input done);
    modport seq (input run, output ready, output done);
endinterface : cpbc_seq_if

// ==== testbench/cpbc_host_model.sv ====
// cpbc_host_model: host processor model, an apb master on pclk.
// assumes the bench calls xfer from one process at a time.
`timescale 1ns/1ps
module cpbc_host_model (
    input wire logic pclk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic [11:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] pwdata
);
    // bus idle from time zero
    initial begin
        paddr = 12'h000;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0000_0000;
    end
    // ------------------------------------------------------------
    // one transfer: setup, access until pready, then release
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // request held until pready seen at an edge
        // no cycle limit here: only the bench timeout ends a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : cpbc_host_model

// ==== testbench/test_cpbc_boot_ctrl.sv ====
// test_cpbc_boot_ctrl: self-checking bench for the boot control block.
// assumes the host model drives apb; bench drives reset and the default delay.
`timescale 1ns/1ps
module test_cpbc_boot_ctrl;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [7:0] dflt_delay, res, code, display_delay;
    logic processor_run, dering_en, busy, init_done_irq;
    logic [3:0] report_en;
    int err_count = 0, n_checks = 0, cyc = 0, nb = 0, ni = 0;
    // ------------------------------------------------------------
    // clock, timeout and instances
    // ------------------------------------------------------------
    always #4 pclk = ~pclk;
    // hang guard, far above the expected run
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_count++;
            finish_test();
        end
    end
    cpbc_host_model host_u (.pclk(pclk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata));
    cpbc_boot_ctrl dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .default_display_delay(dflt_delay),
        .processor_run(processor_run), .dering_en(dering_en),
        .display_delay(display_delay), .report_en(report_en), .busy(busy),
        .init_done_irq(init_done_irq));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        host_u.xfer(1'b1, a, v, d, err);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        host_u.xfer(1'b0, a, 32'h0000_0000, d, err);
    endtask : rd
    // launch a command, then fetch its return code
    task automatic cmd(input logic [7:0] c, input logic en);
        wr(cpbc_pkg::OFF_CMD, {23'h000000, en, c});
        rd(cpbc_pkg::OFF_RESULT);
        res = d[7:0];
    endtask : cmd
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        dflt_delay = 8'h07;
        repeat (5) @(posedge pclk);
        chk("run in reset", processor_run, 32'h0);
        chk("dering in reset", dering_en, 32'h1);
        presetn <= 1'b1;
        rd(cpbc_pkg::OFF_RUN);
        chk("run reg", d, 32'h0);
        rd(12'hffc);
        chk("unmapped err", err, 32'h1);
        rd(cpbc_pkg::OFF_VERSION);
        chk("version halted", d, 32'h0);
        cmd(cpbc_pkg::CMD_DERING_OFF, 1'b0);
        chk("cmd halted", res, cpbc_pkg::RC_NOT_READY);
        // configuration while halted, then enable
        wr(cpbc_pkg::OFF_DELAY, 32'h0000_002a);
        wr(cpbc_pkg::OFF_ADDR, 32'h0000_0000);
        wr(cpbc_pkg::OFF_SIZE, 32'h0000_0000);
        chk("delay default", display_delay, 32'h07);
        wr(cpbc_pkg::OFF_RUN, 32'h0000_0001);
        fork
            // busy span and completion pulse count
            for (int i = 0; i < 300; i++) begin
                @(posedge pclk);
                if (busy === 1'b1) nb++;
                if (init_done_irq === 1'b1) ni++;
            end
            begin
                rd(cpbc_pkg::OFF_STATUS);
                chk("status in init", d, 32'h1);
                rd(cpbc_pkg::OFF_VERSION);
                chk("version in init", d, 32'h0);
                cmd(cpbc_pkg::CMD_DERING_OFF, 1'b0);
                chk("cmd in init", res, cpbc_pkg::RC_NOT_READY);
            end
        join
        chk("busy span", nb >= cpbc_pkg::INIT_CYCLES && nb <= cpbc_pkg::INIT_CYCLES + 3, 1);
        chk("done pulses", ni, 32'h1);
        chk("run out", processor_run, 32'h1);
        rd(cpbc_pkg::OFF_STATUS);
        chk("status ready", d, 32'h6);
        wr(cpbc_pkg::OFF_STATUS, 32'h0000_0004);
        rd(cpbc_pkg::OFF_STATUS);
        chk("done cleared", d, 32'h2);
        rd(cpbc_pkg::OFF_VERSION);
        chk("version", d, {cpbc_pkg::PRODUCT_NUMBER, cpbc_pkg::VER_MAJOR,
            cpbc_pkg::VER_MINOR, cpbc_pkg::VER_PATCH});
        chk("fields", {d[15:12], d[11:8], d[7:0]}, {cpbc_pkg::VER_MAJOR,
            cpbc_pkg::VER_MINOR, cpbc_pkg::VER_PATCH});
        cmd(cpbc_pkg::CMD_DERING_OFF, 1'b0);
        chk("dering off rc", res, cpbc_pkg::RC_SUCCESS);
        chk("dering off", dering_en, 32'h0);
        cmd(cpbc_pkg::CMD_DERING_ON, 1'b0);
        chk("dering on", dering_en, 32'h1);
        // unknown code is refused once the processor is ready
        cmd(8'h00, 1'b0);
        chk("bad cmd rc", res, cpbc_pkg::RC_BAD_CMD);
        cmd(cpbc_pkg::CMD_DISPLAY_DELAY, 1'b0);
        chk("delay rc", res, cpbc_pkg::RC_SUCCESS);
        chk("delay host", display_delay, 32'h2a);
        dflt_delay <= 8'h09;
        @(posedge pclk);
        @(posedge pclk);
        chk("delay kept", display_delay, 32'h2a);
        // enabled reports with null address are refused
        for (int i = 0; i < 4; i++) begin
            code = cpbc_pkg::CMD_REPORT_BUF + 8'(i);
            cmd(code, 1'b1);
            chk("null addr rc", res, cpbc_pkg::RC_BAD_PARAM);
            chk("null addr en", report_en, 32'h0);
        end
        wr(cpbc_pkg::OFF_ADDR, 32'h0000_1000);
        cmd(cpbc_pkg::CMD_USER_REPORT, 1'b1);
        chk("zero size rc", res, cpbc_pkg::RC_BAD_PARAM);
        wr(cpbc_pkg::OFF_SIZE, 32'h0000_0040);
        for (int i = 0; i < 4; i++) begin
            code = cpbc_pkg::CMD_REPORT_BUF + 8'(i);
            cmd(code, 1'b1);
            chk("report rc", res, cpbc_pkg::RC_SUCCESS);
            chk("report en", report_en, (32'h1 << (i + 1)) - 32'h1);
        end
        wr(cpbc_pkg::OFF_RUN, 32'h0000_0000);
        rd(cpbc_pkg::OFF_STATUS);
        chk("halted", processor_run, 32'h0);
        chk("status halted", d, 32'h0);
        chk("delay default back", display_delay, 32'h09);
        finish_test();
    end
endmodule : test_cpbc_boot_ctrl
